/* File: shared/hwdcl_pkg.sv */
// Register map, reset values and state codes for the hardware watchdog clear/lock block
package hwdcl_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_VALUE = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_LOCK = 12'h014;
    // Reset values and keys
    localparam logic [DATA_W-1:0] RELOAD_RST = 32'h0000ffff;
    localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 32'h1acce551;
    localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 32'he5331aae;
    localparam logic [DATA_W-1:0] LOCK_RD_LOCKED = 32'h00000001;
    localparam logic [DATA_W-1:0] LOCK_RD_OPEN = 32'h00000000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
    // Field layout
    localparam int CLEAR_W = 8;
    localparam int CTL_IRQ_EN_BIT = 0;
    localparam int CTL_RST_EN_BIT = 1;
    localparam int STAT_RAW_BIT = 0;
    localparam logic CTL_IRQ_EN_RST = 1'b1;
    localparam logic CTL_RST_EN_RST = 1'b1;
    // Lock tracker states
    typedef enum logic [1:0] {
        HWDCL_LOCKED = 2'b00,
        HWDCL_KEY1 = 2'b01,
        HWDCL_NOCTL = 2'b10,
        HWDCL_OPEN = 2'b11
    } hwdcl_lock_e;
endpackage : hwdcl_pkg

/* File: hw/hwdcl_counter.sv */
// Down-counter of the watchdog with reload and zero detect
`timescale 1ns/1ns
module hwdcl_counter #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] INIT = 32'h0000ffff
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    // State
    output logic [WIDTH-1:0] count,
    output logic zero_hit
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic zero_r;
    logic zero_nxt;

    always_comb
    begin
        count_nxt = count_r;
        zero_nxt = 1'b0;
        if (load)
        begin
            count_nxt = load_val;
        end
        else if (run)
        begin
            // Reaching zero reloads rather than wrapping
            if (count_r == '0)
            begin
                zero_nxt = 1'b1;
                count_nxt = load_val;
            end
            else
            begin
                count_nxt = count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_r <= INIT;
            zero_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            zero_r <= zero_nxt;
        end
    end

    assign count = count_r;
    assign zero_hit = zero_r;
endmodule : hwdcl_counter

/* File: hw/hwdcl_watchdog.sv */
// Hardware watchdog with two-write clear sequence, raw status and two-key register lock
//
// How it works
// RULE1: Byte then its inverse clears irq, reloads
// RULE2: Clear register reads zero, no side effect
// RULE3: Only exact inverse second write clears
// RULE4: Any clear attempt re-locks the registers
// RULE5: Status bit shows timeout; writes ignored
// RULE6: Status bits 7..1 read zero
// RULE7: First key unlocks all but control
// RULE8: Inverted key next unlocks control too
// RULE9: Other value or order relocks everything
// RULE10: Lock reads 0 released, 1 locked
// RULE11: Locked registers readable, writes dropped
// RULE12: Only system reset initialises this state
// RULE13: Tool break stops counter if configured
// RULE14: Software writes key before standby
// RULE15: Handlers relock first thing
// RULE16: Enable low stops, clears; high reloads
// RULE17: Reset needs counter enable as well
// RULE18: Reload resets 0xffff; write reloads, clears (code: the write reloads the counter only while counter_irq_enable_r is 1)
// RULE19: Counts down from reset without software
// RULE20: Zero sets flag; again with flag resets
// RULE21: Foreign write discards partial sequences
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module hwdcl_watchdog #(
    parameter int CNT_W = 32
) (
    // Clock and system reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hwdcl_pkg::ADDR_W-1:0] paddr,
    input wire logic [hwdcl_pkg::DATA_W-1:0] pwdata,
    output logic [hwdcl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Debug break
    input wire logic dbg_break,
    input wire logic dbg_stop_cfg,
    // Watchdog outputs
    output logic wd_irq,
    output logic wd_reset_req
);
    import hwdcl_pkg::*;

    // Tool break is asynchronous to clk
    logic brk_s1_r;
    logic brk_s2_r;

    hwdcl_lock_e lock_r;
    hwdcl_lock_e lock_nxt;
    logic [CNT_W-1:0] hw_wd_reload_value_r;
    logic [CNT_W-1:0] hw_wd_reload_value_nxt;
    logic counter_irq_enable_r;
    logic counter_irq_enable_nxt;
    logic timeout_reset_enable_r;
    logic timeout_reset_enable_nxt;
    logic raw_timeout_flag_r;
    logic raw_timeout_flag_nxt;
    logic clr_pend_r;
    logic clr_pend_nxt;
    logic [CLEAR_W-1:0] clr_first_r;
    logic [CLEAR_W-1:0] clr_first_nxt;
    logic rst_req_r;
    logic rst_req_nxt;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] prdata_nxt;

    logic wr;
    logic setup;
    logic mapped;
    logic regs_open;
    logic ctl_open;
    logic run;
    logic load;
    logic [CNT_W-1:0] count;
    logic zero_hit;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign mapped = (paddr == OFF_RELOAD) || (paddr == OFF_VALUE) || (paddr == OFF_CONTROL)
                  || (paddr == OFF_CLEAR) || (paddr == OFF_STATUS) || (paddr == OFF_LOCK);
    assign regs_open = (lock_r != HWDCL_LOCKED); // RULE7 RULE11
    assign ctl_open = (lock_r == HWDCL_OPEN); // RULE8
    assign run = counter_irq_enable_r && !(brk_s2_r && dbg_stop_cfg); // RULE13 RULE16 RULE19

    hwdcl_counter #(
        .WIDTH(CNT_W),
        .INIT(RELOAD_RST[CNT_W-1:0])
    ) u_counter (
        .clk(clk),
        .rst(rst),
        .run(run),
        .load(load),
        .load_val(hw_wd_reload_value_nxt),
        .count(count),
        .zero_hit(zero_hit)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            brk_s1_r <= 1'b0;
            brk_s2_r <= 1'b0;
        end
        else
        begin
            brk_s1_r <= dbg_break;
            brk_s2_r <= brk_s1_r;
        end
    end

    // Register writes, lock and clear trackers
    always_comb
    begin
        lock_nxt = lock_r;
        hw_wd_reload_value_nxt = hw_wd_reload_value_r;
        counter_irq_enable_nxt = counter_irq_enable_r;
        timeout_reset_enable_nxt = timeout_reset_enable_r;
        clr_pend_nxt = clr_pend_r;
        clr_first_nxt = clr_first_r;
        load = 1'b0;
        raw_timeout_flag_nxt = raw_timeout_flag_r;
        rst_req_nxt = rst_req_r;
        if (wr && mapped)
        begin
            if (paddr == OFF_LOCK)
            begin
                clr_pend_nxt = 1'b0; // RULE21
                if (pwdata == UNLOCK_KEY1)
                begin
                    lock_nxt = HWDCL_KEY1; // RULE7
                end
                else if (pwdata == UNLOCK_KEY2 && lock_r == HWDCL_KEY1)
                begin
                    lock_nxt = HWDCL_OPEN; // RULE8
                end
                else
                begin
                    lock_nxt = HWDCL_LOCKED; // RULE9
                end
            end
            else if (regs_open)
            begin
                // A foreign write in the middle of the key pair forfeits the control unlock
                if (lock_r == HWDCL_KEY1)
                begin
                    lock_nxt = HWDCL_NOCTL; // RULE9 RULE21
                end
                if (paddr != OFF_CLEAR)
                begin
                    clr_pend_nxt = 1'b0; // RULE21
                end
                unique case (paddr)
                    OFF_RELOAD:
                    begin
                        hw_wd_reload_value_nxt = pwdata[CNT_W-1:0];
                        load = counter_irq_enable_r; // RULE18
                        raw_timeout_flag_nxt = 1'b0; // RULE18
                    end
                    OFF_CONTROL:
                    begin
                        if (ctl_open) // RULE8
                        begin
                            counter_irq_enable_nxt = pwdata[CTL_IRQ_EN_BIT];
                            timeout_reset_enable_nxt = pwdata[CTL_RST_EN_BIT];
                            if (!pwdata[CTL_IRQ_EN_BIT])
                            begin
                                raw_timeout_flag_nxt = 1'b0; // RULE16
                            end
                            else if (!counter_irq_enable_r)
                            begin
                                load = 1'b1; // RULE16
                            end
                        end
                    end
                    OFF_CLEAR:
                    begin
                        if (!clr_pend_r)
                        begin
                            clr_pend_nxt = 1'b1;
                            clr_first_nxt = pwdata[CLEAR_W-1:0];
                        end
                        else
                        begin
                            clr_pend_nxt = 1'b0;
                            lock_nxt = HWDCL_LOCKED; // RULE4
                            if (pwdata[CLEAR_W-1:0] == ~clr_first_r) // RULE3
                            begin
                                raw_timeout_flag_nxt = 1'b0; // RULE1
                                load = 1'b1; // RULE1
                            end
                        end
                    end
                    default:
                    begin
                        // Value and status registers ignore writes
                    end
                endcase
            end
        end
        // A timeout in the same cycle as a clear wins
        if (zero_hit)
        begin
            if (raw_timeout_flag_r && timeout_reset_enable_r && counter_irq_enable_r)
            begin
                rst_req_nxt = 1'b1; // RULE17 RULE20
            end
            raw_timeout_flag_nxt = 1'b1; // RULE20
        end
    end

    // Read data latched in the setup phase; reads have no side effects
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (setup && !pwrite)
        begin
            prdata_nxt = ZERO_WORD; // RULE2 RULE6
            unique case (paddr)
                OFF_RELOAD: prdata_nxt[CNT_W-1:0] = hw_wd_reload_value_r;
                OFF_VALUE: prdata_nxt[CNT_W-1:0] = count;
                OFF_CONTROL:
                begin
                    prdata_nxt[CTL_IRQ_EN_BIT] = counter_irq_enable_r;
                    prdata_nxt[CTL_RST_EN_BIT] = timeout_reset_enable_r;
                end
                OFF_STATUS: prdata_nxt[STAT_RAW_BIT] = raw_timeout_flag_r; // RULE5
                OFF_LOCK: prdata_nxt = regs_open ? LOCK_RD_OPEN : LOCK_RD_LOCKED; // RULE10
                default: prdata_nxt = ZERO_WORD;
            endcase
        end
    end

    // No soft reset input reaches here: only rst initialises this state
    always_ff @(posedge clk)
    begin
        if (rst) // RULE12
        begin
            lock_r <= HWDCL_LOCKED; // RULE10
            clr_pend_r <= 1'b0;
            clr_first_r <= '0;
        end
        else
        begin
            lock_r <= lock_nxt;
            clr_pend_r <= clr_pend_nxt;
            clr_first_r <= clr_first_nxt;
        end
    end

    // Configuration keeps its value through any software-level reset
    always_ff @(posedge clk)
    begin
        if (rst) // RULE12
        begin
            hw_wd_reload_value_r <= RELOAD_RST[CNT_W-1:0]; // RULE18
            counter_irq_enable_r <= CTL_IRQ_EN_RST; // RULE19
            timeout_reset_enable_r <= CTL_RST_EN_RST;
        end
        else
        begin
            hw_wd_reload_value_r <= hw_wd_reload_value_nxt;
            counter_irq_enable_r <= counter_irq_enable_nxt;
            timeout_reset_enable_r <= timeout_reset_enable_nxt;
        end
    end

    // Timeout status; the reset request stays up until the system reset
    always_ff @(posedge clk)
    begin
        if (rst) // RULE12
        begin
            raw_timeout_flag_r <= 1'b0;
            rst_req_r <= 1'b0;
        end
        else
        begin
            raw_timeout_flag_r <= raw_timeout_flag_nxt;
            rst_req_r <= rst_req_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata_r <= ZERO_WORD;
        end
        else
        begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wd_irq = raw_timeout_flag_r && counter_irq_enable_r;
    assign wd_reset_req = rst_req_r;
endmodule : hwdcl_watchdog

/* File: test/hwdcl_watchdog_assertions.sv */
// Port-level assertions of the watchdog clear/lock block
`timescale 1ns/1ns
module hwdcl_watchdog_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hwdcl_pkg::ADDR_W-1:0] paddr,
    input wire logic [hwdcl_pkg::DATA_W-1:0] pwdata,
    input wire logic [hwdcl_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Debug and watchdog outputs
    input wire logic dbg_break,
    input wire logic dbg_stop_cfg,
    input wire logic wd_irq,
    input wire logic wd_reset_req
);
    import hwdcl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic rd_acc;
    logic wr_acc;
    logic hit;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    assign hit = paddr inside {OFF_RELOAD, OFF_VALUE, OFF_CONTROL, OFF_CLEAR, OFF_STATUS, OFF_LOCK};
    // Lock read following a lock write, with or without an idle cycle between
    sequence lk_rd;
        psel && !penable && !pwrite && paddr == OFF_LOCK ##1 rd_acc;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    slverr_map_a: assert property (pslverr == (psel && penable && !hit)) else $error("pslverr wrong");
    key_open_a: assert property (
        wr_acc && paddr == OFF_LOCK && pwdata == UNLOCK_KEY1 ##[1:2] lk_rd |-> prdata == LOCK_RD_OPEN)
        else $error("lock not open after key");
    bad_key_a: assert property (
        wr_acc && paddr == OFF_LOCK && pwdata != UNLOCK_KEY1 && pwdata != UNLOCK_KEY2 ##[1:2] lk_rd
        |-> prdata == LOCK_RD_LOCKED) else $error("lock not engaged");
    clr_read_a: assert property (rd_acc && paddr == OFF_CLEAR |-> prdata == ZERO_WORD)
        else $error("clear read not zero");
    stat_rsvd_a: assert property (rd_acc && paddr == OFF_STATUS |-> prdata[31:1] == 31'h00000000)
        else $error("status reserved bits set");
    stat_raw_a: assert property (rd_acc && paddr == OFF_STATUS && $past(wd_irq) |-> prdata[0])
        else $error("status bit missing");
    req_hold_a: assert property (wd_reset_req |=> wd_reset_req) else $error("reset request dropped");
    req_cause_a: assert property ($rose(wd_reset_req) |-> $past(wd_irq))
        else $error("reset request without flag");
    rst_quiet_a: assert property ($fell(rst) |-> !wd_irq && !wd_reset_req)
        else $error("outputs active after reset");
    cover property (wr_acc && paddr == OFF_CLEAR);
    cover property ($rose(wd_irq));
    cover property ($rose(wd_reset_req));
endmodule : hwdcl_watchdog_assertions

bind hwdcl_watchdog hwdcl_watchdog_assertions u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dbg_break(dbg_break),
    .dbg_stop_cfg(dbg_stop_cfg), .wd_irq(wd_irq), .wd_reset_req(wd_reset_req)
);

/* File: test/hwdcl_watchdog_test.sv */
// Self-checking bench of the watchdog clear/lock block
`timescale 1ns/1ns
module hwdcl_watchdog_test;
    import hwdcl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic dbg_break = 1'b0;
    logic dbg_stop_cfg = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h00000000;
    logic [DATA_W-1:0] prdata, rd, v1, m_reload, m_ctl;
    logic pready, pslverr, wd_irq, wd_reset_req, err;
    logic [7:0] key;
    int fails = 0;
    int cmp_count = 0;
    int m_lock, m_half, reload;
    always #20 clk = ~clk;
    hwdcl_watchdog DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dbg_break(dbg_break),
        .dbg_stop_cfg(dbg_stop_cfg), .wd_irq(wd_irq), .wd_reset_req(wd_reset_req)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    // Holds the request until pready is seen high; only the bench's 8000-cycle limit ends a hang
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Lock model: 0 locked, 1 first key, 2 open but control, 3 open
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
        if (a == OFF_LOCK)
            m_lock = (d == UNLOCK_KEY1) ? 1 : (d == UNLOCK_KEY2 && m_lock == 1) ? 3 : 0;
        else if (a == OFF_CLEAR && m_lock != 0)
        begin
            m_lock = m_half ? 0 : (m_lock == 1) ? 2 : m_lock;
            m_half = 1 - m_half;
        end
        else if (m_lock != 0)
        begin
            if (a == OFF_RELOAD)
                m_reload = d;
            if (a == OFF_CONTROL && m_lock == 3)
                m_ctl = {30'h00000000, d[1:0]};
            if (m_lock == 1)
                m_lock = 2;
        end
        if (a != OFF_CLEAR)
            m_half = 0;
    endtask : wr
    task automatic sweep();
        xfer(OFF_LOCK, 1'b0, ZERO_WORD);
        chk(rd, m_lock == 0 ? LOCK_RD_LOCKED : LOCK_RD_OPEN);
        xfer(OFF_RELOAD, 1'b0, ZERO_WORD);
        chk(rd, m_reload);
        xfer(OFF_CONTROL, 1'b0, ZERO_WORD);
        chk(rd, m_ctl);
        xfer(OFF_CLEAR, 1'b0, ZERO_WORD);
        chk(rd, ZERO_WORD);
    endtask : sweep
    task automatic rstat(input logic f);
        xfer(OFF_STATUS, 1'b0, ZERO_WORD);
        chk(rd, {31'h00000000, f});
    endtask : rstat
    // sel 0 waits for the interrupt, sel 1 for the reset request
    task automatic wait_hi(input logic sel, input int lim);
        int n;
        n = 0;
        while ((sel ? wd_reset_req : wd_irq) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_hi
    task automatic mres();
        m_lock = 0;
        m_half = 0;
        m_reload = RELOAD_RST;
        m_ctl = {30'h00000000, CTL_RST_EN_RST, CTL_IRQ_EN_RST};
    endtask : mres
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (8000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(82441));
        mres();
        reload = 150 + ($urandom % 50);
        key = 8'($urandom);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        sweep();
        rstat(1'b0);
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        chk({31'h00000000, rd < RELOAD_RST}, 32'h00000001);
        $display("reset test done");
        wr(OFF_RELOAD, reload);
        sweep();
        wr(OFF_LOCK, UNLOCK_KEY1);
        sweep();
        wr(OFF_CONTROL, ZERO_WORD);
        wr(OFF_RELOAD, reload);
        sweep();
        wr(OFF_LOCK, $urandom & 32'hfffffff0);
        sweep();
        $display("lock test done");
        wr(OFF_LOCK, UNLOCK_KEY1);
        wr(OFF_LOCK, UNLOCK_KEY2);
        wait_hi(1'b0, 2 * reload);
        chk({31'h00000000, wd_irq}, 32'h00000001);
        rstat(1'b1);
        wr(OFF_LOCK, UNLOCK_KEY1);
        wr(OFF_CLEAR, {24'h000000, key});
        wr(OFF_CLEAR, {24'h000000, key ^ 8'h5a});
        rstat(1'b1);
        sweep();
        wr(OFF_LOCK, UNLOCK_KEY1);
        wr(OFF_CLEAR, {24'h000000, key});
        wr(OFF_CLEAR, {24'h000000, ~key});
        rstat(1'b0);
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        chk({31'h00000000, rd <= reload && rd + 40 > reload}, 32'h00000001);
        sweep();
        $display("clear test done");
        dbg_stop_cfg <= 1'b1;
        dbg_break <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        v1 = rd;
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        chk(rd, v1);
        dbg_stop_cfg <= 1'b0;
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        v1 = rd;
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        chk({31'h00000000, rd != v1}, 32'h00000001);
        dbg_break <= 1'b0;
        wr(OFF_LOCK, UNLOCK_KEY1);
        wr(OFF_LOCK, UNLOCK_KEY2);
        wr(OFF_CONTROL, 32'h00000002);
        sweep();
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        v1 = rd;
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        chk(rd, v1);
        wr(OFF_CONTROL, 32'h00000003);
        xfer(OFF_VALUE, 1'b0, ZERO_WORD);
        chk({31'h00000000, rd + 20 > reload}, 32'h00000001);
        $display("enable test done");
        wait_hi(1'b1, 3 * reload);
        chk({31'h00000000, wd_reset_req}, 32'h00000001);
        xfer(12'h020, 1'b0, ZERO_WORD);
        chk({rd[30:0], err}, 32'h00000001);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mres();
        chk({31'h00000000, wd_reset_req}, 32'h00000000);
        sweep();
        $display("timeout test done");
        give_verdict();
    end
endmodule : hwdcl_watchdog_test
